// ---- rtl/isr_pkg.sv ----
package isr_pkg;
   // byte offsets of the word-aligned registers
   localparam logic [7:0] OFS_CTL0 = 8'h00;
   localparam logic [7:0] OFS_CTL1 = 8'h04;
   localparam logic [7:0] OFS_OWN0 = 8'h08;
   localparam logic [7:0] OFS_OWN1 = 8'h0c;
   localparam logic [7:0] OFS_DATA = 8'h10;
   localparam logic [7:0] OFS_STAT0 = 8'h14;
   localparam logic [7:0] OFS_STAT1 = 8'h18;
   // reset values
   localparam logic [15:0] RST_REG = 16'h0000;
   // writable bits per register, reserved bits stay zero
   localparam logic [15:0] MSK_CTL0 = 16'h3ffb;
   localparam logic [15:0] MSK_CTL1 = 16'h1f3f;
   localparam logic [15:0] MSK_OWN0 = 16'h83ff;
   localparam logic [15:0] MSK_OWN1 = 16'h00ff;
   localparam logic [15:0] MSK_ERR = 16'hdf00;
   // control_reg_0 fields
   localparam int C0_EN = 0;
   localparam int C0_SMB = 1;
   localparam int C0_ROLE = 3;
   localparam int C0_ARP = 4;
   localparam int C0_PEC = 5;
   localparam int C0_GC = 6;
   localparam int C0_NOSTR = 7;
   localparam int C0_START = 8;
   localparam int C0_STOP = 9;
   localparam int C0_ACK = 10;
   localparam int C0_POS = 11;
   localparam int C0_PECTX = 12;
   localparam int C0_ALERT = 13;
   localparam int C0_SRST = 15;
   // control_reg_1 fields
   localparam int C1_ERROR_IRQ_ENABLE = 8;
   localparam int C1_EVENT_IRQ_ENABLE = 9;
   localparam int C1_BUFFER_IRQ_ENABLE = 10;
   localparam int C1_DMA = 11;
   localparam int C1_LAST = 12;
   // own address fields
   localparam int A0_W10 = 15;
   localparam int A1_DUAL = 0;
   // status_0 fields
   localparam int S_SB = 0;
   localparam int S_ADD = 1;
   localparam int S_BTC = 2;
   localparam int S_ADD10 = 3;
   localparam int S_STP = 4;
   localparam int S_RX_BUFFER_FULL = 6;
   localparam int S_TBE = 7;
   localparam int S_BUS_ERROR = 8;
   localparam int S_ARB = 9;
   localparam int S_ACK_ERROR = 10;
   localparam int S_OVERRUN_UNDERRUN = 11;
   localparam int S_PEC_MISMATCH = 12;
   localparam int S_TO = 14;
   localparam int S_ALERT = 15;
endpackage

// ---- rtl/isr_regs.sv ----
module isr_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // bus lines, sampled
   input wire logic scl_i,
   input wire logic sda_i,
   // events from the transfer engine
   input wire logic ev_start_sent,
   input wire logic ev_addr_sent,
   input wire logic ev_hdr10_sent,
   input wire logic ev_byte_done,
   input wire logic ev_shift_load,
   input wire logic shift_empty,
   input wire logic ev_rx_load,
   input wire logic [7:0] rx_byte,
   input wire logic [7:0] rx_shift_byte,
   input wire logic ev_pec_done,
   input wire logic ev_pec_mismatch,
   input wire logic ev_timeout,
   input wire logic ev_bus_err,
   input wire logic ev_arb_lost,
   input wire logic ev_ack_err,
   input wire logic ev_ovr_udr,
   input wire logic ev_alert,
   // received address
   input wire logic addr_valid,
   input wire logic addr_is10,
   input wire logic [9:0] addr_in,
   // controls to the engine
   output logic [15:0] ctl0_o,
   output logic [5:0] clk_mhz_o,
   output logic [7:0] tx_byte_o,
   output logic ack_out_o,
   output logic pec_byte_o,
   output logic scl_stretch_o,
   output logic is_master_o,
   output logic addr_match_o,
   output logic second_match_o,
   // alert pin, open drain
   output logic alert_o,
   output logic alert_oe_n,
   // interrupts and dma
   output logic irq_event_o,
   output logic irq_error_o,
   output logic dma_tx_req_o,
   output logic dma_rx_req_o,
   output logic dma_last_o
);
   logic [15:0] ctl0_r, ctl0_nxt, ctl1_r, own0_r, own1_r, stat_r, stat_nxt;
   logic [7:0] data_r;
   logic srst_r, rst, ack_r, stat_rd_r, ack_next_r, pec_next_r, master_r;
   logic [31:0] dat_r;
   logic acc, wr, rd, en;
   logic wr_ctl0, wr_data, rd_data, rd_stat, rd_stat1;
   logic [15:0] wd_ctl0, wd_ctl1, wd_own0, wd_own1, wd_stat;
   logic scl_m, scl_s, sda_m, sda_s, scl_p, sda_p, start_det, stop_det;
   logic irq_ev_r, irq_er_r, dtx_r, drx_r, ackout_r, pecb_r, str_r;
   logic match_r, match2_r, aoe_n_r;

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] nw, input logic [3:0] sel, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      if (sel[0])
      begin
         v[7:0] = nw[7:0];
      end
      if (sel[1])
      begin
         v[15:8] = nw[15:8];
      end
      return v & m;
   endfunction

   // the soft reset bit itself only falls back on the port reset
   assign rst = !rst_n || srst_r;
   assign en = ctl0_r[isr_pkg::C0_EN];
   assign acc = cyc_i && stb_i && !ack_r;
   assign wr = acc && we_i;
   assign rd = acc && !we_i;
   assign wr_ctl0 = wr && adr_i == isr_pkg::OFS_CTL0;
   assign wr_data = wr && adr_i == isr_pkg::OFS_DATA;
   assign rd_data = rd && adr_i == isr_pkg::OFS_DATA;
   assign rd_stat = rd && adr_i == isr_pkg::OFS_STAT0;
   assign rd_stat1 = rd && adr_i == isr_pkg::OFS_STAT1;
   assign wd_ctl0 = merge(ctl0_r, dat_i, sel_i, isr_pkg::MSK_CTL0);
   assign wd_ctl1 = merge(ctl1_r, dat_i, sel_i, isr_pkg::MSK_CTL1);
   assign wd_own0 = merge(own0_r, dat_i, sel_i, isr_pkg::MSK_OWN0);
   assign wd_own1 = merge(own1_r, dat_i, sel_i, isr_pkg::MSK_OWN1);
   assign wd_stat = merge(stat_r, dat_i, sel_i, 16'hffff);

   // bus lines come from another domain: two stages before any use
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
      end
      else
      begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end
   assign start_det = en && scl_s && scl_p && sda_p && !sda_s;
   assign stop_det = en && scl_s && scl_p && !sda_p && sda_s;

   // soft reset bit
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         srst_r <= 1'b0;
      end
      else if (wr_ctl0 && sel_i[1])
      begin
         srst_r <= dat_i[isr_pkg::C0_SRST];
      end
   end

   // control_reg_0 with its hardware side effects
   always_comb
   begin
      ctl0_nxt = wr_ctl0 ? wd_ctl0 : ctl0_r;
      ctl0_nxt[isr_pkg::C0_SRST] = 1'b0;
      if (!ctl0_nxt[isr_pkg::C0_EN])
      begin
         ctl0_nxt[isr_pkg::C0_POS] = 1'b0;
         ctl0_nxt[isr_pkg::C0_ACK] = 1'b0;
         ctl0_nxt[isr_pkg::C0_START] = 1'b0;
         ctl0_nxt[isr_pkg::C0_PECTX] = 1'b0;
         ctl0_nxt[isr_pkg::C0_ALERT] = 1'b0;
      end
      if (ev_pec_done || start_det || stop_det)
      begin
         ctl0_nxt[isr_pkg::C0_PECTX] = 1'b0;
      end
      if (start_det)
      begin
         ctl0_nxt[isr_pkg::C0_START] = 1'b0;
      end
      if (stop_det)
      begin
         ctl0_nxt[isr_pkg::C0_STOP] = 1'b0;
      end
      if (ev_timeout && en)
      begin
         ctl0_nxt[isr_pkg::C0_STOP] = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl0_r <= isr_pkg::RST_REG;
      end
      else
      begin
         ctl0_r <= ctl0_nxt;
      end
   end

   // plain configuration registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl1_r <= isr_pkg::RST_REG;
         own0_r <= isr_pkg::RST_REG;
         own1_r <= isr_pkg::RST_REG;
      end
      else if (wr)
      begin
         if (adr_i == isr_pkg::OFS_CTL1)
         begin
            ctl1_r <= wd_ctl1;
         end
         if (adr_i == isr_pkg::OFS_OWN0)
         begin
            own0_r <= wd_own0;
         end
         if (adr_i == isr_pkg::OFS_OWN1)
         begin
            own1_r <= wd_own1;
         end
      end
   end

   // data buffer; a read under byte done pulls the shift byte in at once
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_r <= 8'h00;
      end
      else if (wr_data && sel_i[0])
      begin
         data_r <= dat_i[7:0];
      end
      else if (ev_rx_load)
      begin
         data_r <= rx_byte;
      end
      else if (rd_data && stat_r[isr_pkg::S_BTC])
      begin
         data_r <= rx_shift_byte;
      end
   end

   // status read arms the two-step clears; the next access consumes it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stat_rd_r <= 1'b0;
      end
      else if (acc)
      begin
         stat_rd_r <= rd_stat;
      end
   end

   // status_0: every hardware set wins over a clear in the same cycle
   always_comb
   begin
      stat_nxt = stat_r;
      if (stat_rd_r && wr_data)
      begin
         stat_nxt[isr_pkg::S_SB] = 1'b0;
         stat_nxt[isr_pkg::S_ADD10] = 1'b0;
      end
      if (stat_rd_r && rd_stat1)
      begin
         stat_nxt[isr_pkg::S_ADD] = 1'b0;
      end
      if ((stat_rd_r && (wr_data || rd_data)) || start_det || stop_det || !en)
      begin
         stat_nxt[isr_pkg::S_BTC] = 1'b0;
      end
      if (stat_rd_r && wr_ctl0)
      begin
         stat_nxt[isr_pkg::S_STP] = 1'b0;
      end
      if (wr_data && !shift_empty)
      begin
         stat_nxt[isr_pkg::S_TBE] = 1'b0;
      end
      if (rd_data && !stat_r[isr_pkg::S_BTC])
      begin
         stat_nxt[isr_pkg::S_RX_BUFFER_FULL] = 1'b0;
      end
      if (wr && adr_i == isr_pkg::OFS_STAT0)
      begin
         stat_nxt = stat_nxt & (wd_stat | ~isr_pkg::MSK_ERR);
      end
      stat_nxt[isr_pkg::S_SB] |= ev_start_sent;
      stat_nxt[isr_pkg::S_ADD10] |= ev_hdr10_sent;
      stat_nxt[isr_pkg::S_ADD] |= ev_addr_sent || match_r;
      stat_nxt[isr_pkg::S_BTC] |= ev_byte_done
         && (master_r || !ctl0_r[isr_pkg::C0_NOSTR]);
      stat_nxt[isr_pkg::S_STP] |= stop_det && !master_r;
      stat_nxt[isr_pkg::S_TBE] |= ev_shift_load;
      stat_nxt[isr_pkg::S_RX_BUFFER_FULL] |= ev_rx_load;
      stat_nxt[isr_pkg::S_BUS_ERROR] |= ev_bus_err;
      stat_nxt[isr_pkg::S_ARB] |= ev_arb_lost;
      stat_nxt[isr_pkg::S_ACK_ERROR] |= ev_ack_err;
      stat_nxt[isr_pkg::S_OVERRUN_UNDERRUN] |= ev_ovr_udr;
      stat_nxt[isr_pkg::S_PEC_MISMATCH] |= ev_pec_mismatch;
      stat_nxt[isr_pkg::S_TO] |= ev_timeout;
      stat_nxt[isr_pkg::S_ALERT] |= ev_alert;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stat_r <= isr_pkg::RST_REG;
      end
      else
      begin
         stat_r <= stat_nxt;
      end
   end

   // master flag: losing arbitration drops straight back to slave
   always_ff @(posedge clk)
   begin
      if (rst || !en)
      begin
         master_r <= 1'b0;
      end
      else if (ev_arb_lost || stop_det)
      begin
         master_r <= 1'b0;
      end
      else if (ev_start_sent)
      begin
         master_r <= 1'b1;
      end
   end

   // ack and pec choice latched for the next byte when position is set
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ack_next_r <= 1'b0;
         pec_next_r <= 1'b0;
      end
      else if (ev_rx_load)
      begin
         ack_next_r <= ctl0_r[isr_pkg::C0_ACK];
         pec_next_r <= ctl0_r[isr_pkg::C0_PECTX];
      end
   end

   // own address compare, general call and second address
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         match_r <= 1'b0;
         match2_r <= 1'b0;
      end
      else
      begin
         match_r <= addr_valid && en && (addr_is10
            ? (own0_r[isr_pkg::A0_W10] && addr_in == own0_r[9:0])
            : ((!own0_r[isr_pkg::A0_W10] && addr_in[7:1] == own0_r[7:1])
            || (own1_r[isr_pkg::A1_DUAL] && addr_in[7:1] == own1_r[7:1])
            || (ctl0_r[isr_pkg::C0_GC] && addr_in[7:1] == 7'h00)));
         match2_r <= addr_valid && en && !addr_is10
            && own1_r[isr_pkg::A1_DUAL] && addr_in[7:1] == own1_r[7:1];
      end
   end

   // registered outputs toward the engine, pins, interrupts and dma
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         {ackout_r, pecb_r, str_r, irq_ev_r, irq_er_r, dtx_r, drx_r} <= 7'h00;
         aoe_n_r <= 1'b1;
      end
      else
      begin
         ackout_r <= (ctl0_r[isr_pkg::C0_POS] ? ack_next_r
            : ctl0_r[isr_pkg::C0_ACK]) && !stat_r[isr_pkg::S_PEC_MISMATCH];
         pecb_r <= ctl0_r[isr_pkg::C0_POS] ? pec_next_r
            : ctl0_r[isr_pkg::C0_PECTX];
         str_r <= master_r || !ctl0_r[isr_pkg::C0_NOSTR];
         aoe_n_r <= !ctl0_r[isr_pkg::C0_ALERT];
         irq_ev_r <= ctl1_r[isr_pkg::C1_EVENT_IRQ_ENABLE] && ((|stat_r[4:0])
            || (ctl1_r[isr_pkg::C1_BUFFER_IRQ_ENABLE] && (|stat_r[7:6])));
         irq_er_r <= ctl1_r[isr_pkg::C1_ERROR_IRQ_ENABLE]
            && (|(stat_r & isr_pkg::MSK_ERR));
         dtx_r <= ctl1_r[isr_pkg::C1_DMA] && stat_r[isr_pkg::S_TBE];
         drx_r <= ctl1_r[isr_pkg::C1_DMA] && stat_r[isr_pkg::S_RX_BUFFER_FULL];
      end
   end

   // wishbone answer one cycle after the request, unmapped reads zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= acc;
         unique case (adr_i)
            isr_pkg::OFS_CTL0: dat_r <= {16'h0000, srst_r, ctl0_r[14:0]};
            isr_pkg::OFS_CTL1: dat_r <= {16'h0000, ctl1_r};
            isr_pkg::OFS_OWN0: dat_r <= {16'h0000, own0_r};
            isr_pkg::OFS_OWN1: dat_r <= {16'h0000, own1_r};
            isr_pkg::OFS_DATA: dat_r <= {24'h00_0000, data_r};
            isr_pkg::OFS_STAT0: dat_r <= {16'h0000, stat_r};
            default: dat_r <= 32'h0000_0000;
         endcase
      end
   end

   assign dat_o = dat_r;
   assign ack_o = ack_r;
   assign ctl0_o = ctl0_r;
   assign clk_mhz_o = ctl1_r[5:0];
   assign tx_byte_o = data_r;
   assign ack_out_o = ackout_r;
   assign pec_byte_o = pecb_r;
   assign scl_stretch_o = str_r;
   assign is_master_o = master_r;
   assign addr_match_o = match_r;
   assign second_match_o = match2_r;
   assign alert_o = 1'b0;
   assign alert_oe_n = aoe_n_r;
   assign irq_event_o = irq_ev_r;
   assign irq_error_o = irq_er_r;
   assign dma_tx_req_o = dtx_r;
   assign dma_rx_req_o = drx_r;
   assign dma_last_o = ctl1_r[isr_pkg::C1_LAST];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_armed_data_write;
      stat_rd_r && wr_data && !ev_start_sent;
   endsequence

   chk_soft_reset_hold: assert property (
      disable iff (!rst_n)
      srst_r |=> stat_r == 16'h0000 && ctl1_r == 16'h0000)
      else $error("soft reset left state");
   chk_alert_drive: assert property (
      ctl0_r[13] |=> !alert_oe_n)
      else $error("alert pin not driven");
   chk_start_clear: assert property (
      start_det |=> !ctl0_r[8])
      else $error("start request not cleared");
   chk_stop_timeout: assert property (
      ev_timeout && en && !stop_det |=> ctl0_r[9])
      else $error("timeout did not set stop");
   chk_arb_slave: assert property (
      ev_arb_lost |=> !master_r && stat_r[9])
      else $error("arbitration loss not handled");
   chk_stop_seen: assert property (
      stop_det && !master_r |=> stat_r[4])
      else $error("stop seen flag not set");
   chk_err_irq: assert property (
      ctl1_r[8] && (|(stat_r & isr_pkg::MSK_ERR)) |=> irq_error_o)
      else $error("error interrupt missing");
   chk_rx_refill: assert property (
      rd_data && stat_r[2] |=> stat_r[6])
      else $error("refill lost rx full");
   chk_sb_clear: assert property (
      s_armed_data_write |=> !stat_r[0])
      else $error("start sent not cleared");
   chk_pec_nack: assert property (
      ev_pec_mismatch |=> ##1 !ack_out_o)
      else $error("nack not forced on pec error");
endmodule

// ---- sim/isr_bus_model.sv ----
// far side of the two-wire bus: drives the sampled scl and sda lines
module isr_bus_model (
   // bus lines
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 24;
   // pull-ups hold both lines high while the bus is free
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // data falls while the clock is high, then the clock goes low
   task automatic start_cond();
      sda <= 1'b0;
      #HALF;
      scl <= 1'b0;
      #HALF;
   endtask
   // data rises while the clock is high; both lines end released
   task automatic stop_cond();
      sda <= 1'b0;
      #HALF;
      scl <= 1'b1;
      #HALF;
      sda <= 1'b1;
      #HALF;
   endtask
endmodule

// ---- sim/testbench.sv ----
`define CHK(n, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("MISMATCH %s exp %h got %h", n, e, g); \
      end \
   end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0] adr_i = 0;
   logic [31:0] dat_i = 0, dat_o;
   logic [3:0] sel_i = 0;
   logic ack_o, scl_i, sda_i;
   logic ev_start_sent = 0, ev_addr_sent = 0, ev_hdr10_sent = 0;
   logic ev_byte_done = 0, ev_shift_load = 0, shift_empty = 0;
   logic ev_rx_load = 0, ev_pec_done = 0, ev_pec_mismatch = 0;
   logic ev_timeout = 0, ev_bus_err = 0, ev_arb_lost = 0;
   logic ev_ack_err = 0, ev_ovr_udr = 0, ev_alert = 0;
   logic addr_valid = 0, addr_is10 = 0;
   logic [7:0] rx_byte = 0, rx_shift_byte = 0, tx_byte_o;
   logic [9:0] addr_in = 0;
   logic [15:0] ctl0_o, q;
   logic [5:0] clk_mhz_o;
   logic ack_out_o, pec_byte_o, scl_stretch_o, is_master_o;
   logic addr_match_o, second_match_o, alert_o, alert_oe_n;
   logic irq_event_o, irq_error_o, dma_tx_req_o, dma_rx_req_o;
   logic dma_last_o;
   int errors = 0, samples_checked = 0, cycles = 0;

   isr_regs i_isr_regs (.*);
   isr_bus_model i_isr_bus_model (.scl(scl_i), .sda(sda_i));

   always #2 clk = ~clk;

   // a hang ends the run through the same closing report
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one classic cycle; ack and read data are taken at the same edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
      @(posedge clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {16'h0000, d};
      sel_i <= 4'h3;
      do
         @(posedge clk);
      while (ack_o !== 1'b1);
      q = dat_o[15:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] m,
                         input logic [15:0] e);
      wb(1'b0, a, 16'h0000);
      `CHK("read", e, q & m)
   endtask

   task automatic t_reset_values();
      for (int i = 0; i < 8; i++)
         rd_chk(8'(4 * i), 16'hffff, 16'h0000);
   endtask

   // reserved bits stay zero after an all-ones write
   task automatic t_reserved();
      logic [7:0] a [4] = '{8'h04, 8'h08, 8'h0c, 8'h10};
      logic [15:0] e [4] = '{16'h1f3f, 16'h83ff, 16'h00ff, 16'h00ff};
      for (int i = 0; i < 4; i++)
      begin
         wb(1'b1, a[i], 16'hffff);
         rd_chk(a[i], 16'hffff, e[i]);
      end
      wb(1'b1, 8'h04, 16'h1f24);
      rd_chk(8'h04, 16'hffff, 16'h1f24);
      `CHK("dma_last", 1'b1, dma_last_o)
      `CHK("clk_mhz", 6'h24, clk_mhz_o)
   endtask

   task automatic t_errors();
      @(posedge clk);
      ev_bus_err <= 1'b1;
      ev_arb_lost <= 1'b1;
      @(posedge clk);
      ev_bus_err <= 1'b0;
      ev_arb_lost <= 1'b0;
      rd_chk(8'h14, 16'h0300, 16'h0300);
      `CHK("irq_error", 1'b1, irq_error_o)
      wb(1'b1, 8'h14, 16'hffff);
      rd_chk(8'h14, 16'h0300, 16'h0300);
      wb(1'b1, 8'h14, 16'hfeff);
      rd_chk(8'h14, 16'h0300, 16'h0200);
      wb(1'b1, 8'h14, 16'hfdff);
      rd_chk(8'h14, 16'h0300, 16'h0000);
   endtask

   task automatic t_events();
      @(posedge clk);
      ev_start_sent <= 1'b1;
      @(posedge clk);
      ev_start_sent <= 1'b0;
      rd_chk(8'h14, 16'h0001, 16'h0001);
      `CHK("irq_event", 1'b1, irq_event_o)
      wb(1'b1, 8'h10, 16'h00a5);
      `CHK("tx_byte", 8'ha5, tx_byte_o)
      rd_chk(8'h14, 16'h0001, 16'h0000);
      @(posedge clk);
      ev_rx_load <= 1'b1;
      rx_byte <= 8'h5a;
      @(posedge clk);
      ev_rx_load <= 1'b0;
      rd_chk(8'h14, 16'h0040, 16'h0040);
      rd_chk(8'h10, 16'h00ff, 16'h005a);
      rd_chk(8'h14, 16'h0040, 16'h0000);
   endtask

   // start and stop requests cleared by conditions seen on the lines
   task automatic t_bus_conditions();
      wb(1'b1, 8'h00, 16'h0301);
      i_isr_bus_model.start_cond();
      rd_chk(8'h00, 16'hffff, 16'h0201);
      i_isr_bus_model.stop_cond();
      repeat (4) @(posedge clk);
      rd_chk(8'h00, 16'hffff, 16'h0001);
      rd_chk(8'h14, 16'h0010, 16'h0010);
      wb(1'b1, 8'h00, 16'h0001);
      rd_chk(8'h14, 16'h0010, 16'h0000);
   endtask

   // disabling the block drops the hardware-cleared control bits
   task automatic t_disable();
      wb(1'b1, 8'h00, 16'h2c01);
      rd_chk(8'h00, 16'hffff, 16'h2c01);
      `CHK("ctl0_o", 16'h2c01, ctl0_o)
      `CHK("alert_o", 1'b0, alert_o)
      `CHK("alert_oe_n", 1'b0, alert_oe_n)
      wb(1'b1, 8'h00, 16'h2c00);
      rd_chk(8'h00, 16'hffff, 16'h0000);
      `CHK("alert_oe_n", 1'b1, alert_oe_n)
   endtask

   // one received address, judged while the match pulse stands
   task automatic addr_try(input logic w, input logic [9:0] a,
                           input logic m, input logic m2);
      @(posedge clk);
      addr_valid <= 1'b1;
      addr_is10 <= w;
      addr_in <= a;
      @(posedge clk);
      addr_valid <= 1'b0;
      @(posedge clk);
      `CHK("addr_match", m, addr_match_o)
      `CHK("second_match", m2, second_match_o)
   endtask

   task automatic t_address();
      wb(1'b1, 8'h00, 16'h0001);
      wb(1'b1, 8'h08, 16'h0066);
      wb(1'b1, 8'h0c, 16'h00a5);
      addr_try(1'b0, 10'h066, 1'b1, 1'b0);
      rd_chk(8'h14, 16'h0002, 16'h0002);
      wb(1'b0, 8'h18, 16'h0000);
      rd_chk(8'h14, 16'h0002, 16'h0000);
      addr_try(1'b0, 10'h0a4, 1'b1, 1'b1);
      addr_try(1'b0, 10'h000, 1'b0, 1'b0);
      wb(1'b1, 8'h00, 16'h0041);
      addr_try(1'b0, 10'h000, 1'b1, 1'b0);
      wb(1'b1, 8'h08, 16'h8266);
      addr_try(1'b1, 10'h266, 1'b1, 1'b0);
      addr_try(1'b0, 10'h066, 1'b0, 1'b0);
   endtask

   // ack, pec, refill, timeout, stretch, master and tx empty paths
   task automatic t_data_path();
      wb(1'b1, 8'h00, 16'h0401);
      rd_chk(8'h00, 16'hffff, 16'h0401);
      `CHK("ack_out", 1'b1, ack_out_o)
      `CHK("stretch", 1'b1, scl_stretch_o)
      @(posedge clk);
      ev_pec_mismatch <= 1'b1;
      @(posedge clk);
      ev_pec_mismatch <= 1'b0;
      rd_chk(8'h14, 16'h1000, 16'h1000);
      `CHK("ack_out", 1'b0, ack_out_o)
      wb(1'b1, 8'h14, 16'hefff);
      wb(1'b1, 8'h00, 16'h0c01);
      rd_chk(8'h14, 16'h1000, 16'h0000);
      `CHK("ack_out", 1'b0, ack_out_o)
      @(posedge clk);
      ev_rx_load <= 1'b1;
      ev_byte_done <= 1'b1;
      rx_byte <= 8'h11;
      rx_shift_byte <= 8'h22;
      @(posedge clk);
      ev_rx_load <= 1'b0;
      ev_byte_done <= 1'b0;
      rd_chk(8'h14, 16'h0044, 16'h0044);
      `CHK("ack_out", 1'b1, ack_out_o)
      `CHK("dma_rx", 1'b1, dma_rx_req_o)
      rd_chk(8'h10, 16'h00ff, 16'h0011);
      rd_chk(8'h14, 16'h0044, 16'h0040);
      rd_chk(8'h10, 16'h00ff, 16'h0022);
      rd_chk(8'h14, 16'h0040, 16'h0000);
      wb(1'b1, 8'h00, 16'h1001);
      rd_chk(8'h00, 16'hffff, 16'h1001);
      `CHK("pec_byte", 1'b1, pec_byte_o)
      @(posedge clk);
      ev_pec_done <= 1'b1;
      @(posedge clk);
      ev_pec_done <= 1'b0;
      rd_chk(8'h00, 16'hffff, 16'h0001);
      `CHK("pec_byte", 1'b0, pec_byte_o)
      @(posedge clk);
      ev_timeout <= 1'b1;
      @(posedge clk);
      ev_timeout <= 1'b0;
      rd_chk(8'h00, 16'hffff, 16'h0201);
      rd_chk(8'h14, 16'h4000, 16'h4000);
      wb(1'b1, 8'h00, 16'h0081);
      rd_chk(8'h00, 16'hffff, 16'h0081);
      `CHK("stretch", 1'b0, scl_stretch_o)
      @(posedge clk);
      ev_start_sent <= 1'b1;
      @(posedge clk);
      ev_start_sent <= 1'b0;
      rd_chk(8'h14, 16'h0001, 16'h0001);
      `CHK("master", 1'b1, is_master_o)
      @(posedge clk);
      ev_arb_lost <= 1'b1;
      @(posedge clk);
      ev_arb_lost <= 1'b0;
      rd_chk(8'h14, 16'h0200, 16'h0200);
      `CHK("master", 1'b0, is_master_o)
      @(posedge clk);
      ev_shift_load <= 1'b1;
      @(posedge clk);
      ev_shift_load <= 1'b0;
      rd_chk(8'h14, 16'h0080, 16'h0080);
      `CHK("dma_tx", 1'b1, dma_tx_req_o)
      wb(1'b1, 8'h10, 16'h00c3);
      rd_chk(8'h14, 16'h0080, 16'h0000);
      @(posedge clk);
      ev_shift_load <= 1'b1;
      shift_empty <= 1'b1;
      @(posedge clk);
      ev_shift_load <= 1'b0;
      wb(1'b1, 8'h10, 16'h003c);
      rd_chk(8'h14, 16'h0080, 16'h0080);
   endtask

   // lines are released here, so the soft reset may be applied
   task automatic t_soft_reset();
      wb(1'b1, 8'h00, 16'h8001);
      rd_chk(8'h00, 16'hffff, 16'h8000);
      rd_chk(8'h04, 16'hffff, 16'h0000);
      wb(1'b1, 8'h00, 16'h0000);
      rd_chk(8'h00, 16'hffff, 16'h0000);
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_values();
      t_reserved();
      t_errors();
      t_events();
      t_bus_conditions();
      t_address();
      t_data_path();
      t_disable();
      t_soft_reset();
      print_verdict();
   end
endmodule
